// *** rtl/pin_sync2.v ***
/*
 * Two flip-flop synchroniser for a bus of asynchronous levels.
 * Assumes the destination clock is i_sys_clk.
 */
`timescale 1ns/1ps
module pin_sync2 #(
    parameter WIDTH = 1
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule // pin_sync2

// *** rtl/pwr_mode_ctrl.v ***
/*
 * Wait/stop power mode controller: gates CPU, watchdog and peripheral
 * clocks, freezes I/O pins, freezes the clock output in stop and in gated wait unless it selects sub, restores the CPU clock
 * source on wake. Assumes CPU and interrupt controller run on i_sys_clk;
 * NMI and wake requests may be asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "pwr_mode_defines.vh"
module pwr_mode_ctrl #(
    parameter NSRC = `WK_NUM,
    parameter NPINS = 8
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_clk_en,
    input wire i_wait_instr,
    input wire i_all_clock_stop_wr,
    input wire [1:0] i_cpu_clk_src,
    input wire i_cpu_div8_select,
    input wire i_main_osc_high_drive,
    input wire i_wdt_osc_source_select,
    input wire i_periph_clk_stop_in_wait,
    input wire i_global_int_enable,
    input wire [NSRC*3-1:0] i_interrupt_priority_level,
    input wire [2:0] i_clk_out_select,
    input wire i_ser_ext_clk,
    input wire i_adc_single_mode,
    input wire i_tmr_ext_or_sub32,
    input wire i_nmi_n,
    input wire [NSRC-1:0] i_periph_irq,
    input wire [NPINS-1:0] i_port_out,
    input wire [NPINS-1:0] i_port_dir,
    input wire i_sub_clk,
    input wire i_f1,
    input wire i_f8,
    input wire i_f32,
    output reg o_in_wait,
    output reg o_in_stop,
    output reg o_cpu_clk_en,
    output reg o_wdt_clk_en,
    output reg o_periph_clk_en,
    output reg o_sub_div32_en,
    output reg o_main_osc_en,
    output reg o_sub_osc_en,
    output reg o_oco_en,
    output reg o_pll_osc_en,
    output reg [1:0] o_cpu_clk_src,
    output reg o_cpu_div8_select,
    output reg o_main_osc_high_drive,
    output reg o_wake_irq,
    output reg [NPINS-1:0] o_port_out,
    output reg [NPINS-1:0] o_port_dir,
    output reg o_clock_output_pin
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    wire [NSRC+4:0] async_bus;
    wire [NSRC+4:0] sync_bus;
    wire nmi_s;
    wire [NSRC-1:0] irq_s;
    wire sub_s;
    wire f1_s;
    wire f8_s;
    wire f32_s;

    assign async_bus = {i_f32, i_f8, i_f1, i_sub_clk, ~i_nmi_n, i_periph_irq};

    pin_sync2 #(
        .WIDTH(NSRC + 5)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(async_bus),
        .o_sync(sync_bus)
    );

    assign irq_s = sync_bus[NSRC-1:0];
    assign nmi_s = sync_bus[NSRC];
    assign sub_s = sync_bus[NSRC+1];
    assign f1_s = sync_bus[NSRC+2];
    assign f8_s = sync_bus[NSRC+3];
    assign f32_s = sync_bus[NSRC+4];

    // ==========================================================
    // Wake qualification
    // ==========================================================
    reg [1:0] state_ff;
    wire periph_wake;

    wake_qualify #(
        .NSRC(NSRC)
    ) u_wake (
        .i_in_stop(state_ff == `ST_STOP),
        .i_periph_clk_stop_in_wait(i_periph_clk_stop_in_wait),
        .i_global_int_enable(i_global_int_enable),
        .i_interrupt_priority_level(i_interrupt_priority_level),
        .i_req(irq_s),
        .i_ser_ext_clk(i_ser_ext_clk),
        .i_adc_single_mode(i_adc_single_mode),
        .i_tmr_ext_or_sub32(i_tmr_ext_or_sub32),
        .o_wake(periph_wake)
    );

    // ==========================================================
    // Mode state machine
    // ==========================================================
    reg [1:0] nxt_state;
    reg [1:0] saved_src_ff;
    reg wake;
    reg [1:0] nxt_src;
    reg nxt_div8;
    reg nxt_hdrv;

    always @* begin
        wake = nmi_s | periph_wake;
        nxt_state = state_ff;
        nxt_src = o_cpu_clk_src;
        nxt_div8 = o_cpu_div8_select;
        nxt_hdrv = o_main_osc_high_drive;
        case (state_ff)
            `ST_NORMAL: begin
                nxt_src = i_cpu_clk_src;
                nxt_div8 = i_cpu_div8_select;
                nxt_hdrv = i_main_osc_high_drive;
                if (i_all_clock_stop_wr) begin
                    nxt_state = `ST_STOP;
                    nxt_div8 = 1'b1;
                    nxt_hdrv = 1'b1;
                end else if (i_wait_instr) begin
                    nxt_state = `ST_WAIT;
                end
            end
            `ST_WAIT: begin
                if (wake) begin
                    nxt_state = `ST_NORMAL;
                    nxt_src = saved_src_ff;
                end
            end
            `ST_STOP: begin
                if (wake) begin
                    nxt_state = `ST_NORMAL;
                    // Saved source returns with divide-by-8 select set, whatever the source
                    nxt_src = saved_src_ff;
                    nxt_div8 = 1'b1;
                end
            end
            default: begin
                nxt_state = `ST_NORMAL;
            end
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_ff <= `ST_NORMAL;
            saved_src_ff <= `CLK_MAIN;
            o_cpu_clk_src <= `CLK_MAIN;
            o_cpu_div8_select <= 1'b1;
            o_main_osc_high_drive <= 1'b1;
            o_wake_irq <= 1'b0;
        end else if (i_clk_en) begin
            state_ff <= nxt_state;
            o_cpu_clk_src <= nxt_src;
            o_cpu_div8_select <= nxt_div8;
            o_main_osc_high_drive <= nxt_hdrv;
            if (state_ff == `ST_NORMAL && nxt_state != `ST_NORMAL) begin
                saved_src_ff <= i_cpu_clk_src;
            end
            o_wake_irq <= (state_ff != `ST_NORMAL) && (nxt_state == `ST_NORMAL) && ~nmi_s;
        end
    end

    // ==========================================================
    // Clock gating and pin hold
    // ==========================================================
    wire next_wait;
    wire next_stop;
    wire next_low;
    reg cko_live;

    assign next_wait = (nxt_state == `ST_WAIT);
    assign next_stop = (nxt_state == `ST_STOP);
    assign next_low = next_wait | next_stop;

    always @* begin
        case (i_clk_out_select)
            `CKO_SUB: cko_live = sub_s;
            `CKO_F8: cko_live = f8_s;
            `CKO_F32: cko_live = f32_s;
            `CKO_F1: cko_live = f1_s;
            default: cko_live = 1'b0;
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_in_wait <= 1'b0;
            o_in_stop <= 1'b0;
            o_cpu_clk_en <= 1'b1;
            o_wdt_clk_en <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_sub_div32_en <= 1'b1;
            o_main_osc_en <= 1'b1;
            o_sub_osc_en <= 1'b1;
            o_oco_en <= 1'b1;
            o_pll_osc_en <= 1'b1;
            o_port_out <= {NPINS{1'b0}};
            o_port_dir <= {NPINS{1'b0}};
            o_clock_output_pin <= 1'b0;
        end else if (i_clk_en) begin
            o_in_wait <= next_wait;
            o_in_stop <= next_stop;
            o_cpu_clk_en <= ~next_low;
            o_wdt_clk_en <= ~next_stop & (~next_wait | i_wdt_osc_source_select);
            o_periph_clk_en <= ~next_stop & ~(next_wait & i_periph_clk_stop_in_wait);
            o_sub_div32_en <= ~next_stop;
            // Oscillators stay up in wait, all off in stop
            o_main_osc_en <= ~next_stop;
            o_sub_osc_en <= ~next_stop;
            o_oco_en <= ~next_stop;
            o_pll_osc_en <= ~next_stop;
            if (~next_low) begin
                o_port_out <= i_port_out;
                o_port_dir <= i_port_dir;
            end
            if (next_stop) begin
                o_clock_output_pin <= o_clock_output_pin;
            end else if (next_wait && i_clk_out_select != `CKO_SUB && i_periph_clk_stop_in_wait) begin
                o_clock_output_pin <= o_clock_output_pin;
            end else begin
                o_clock_output_pin <= cko_live;
            end
        end
    end
endmodule // pwr_mode_ctrl

// *** rtl/pwr_mode_defines.vh ***
/*
 * Constants for the wait/stop power mode controller: state codes, clock
 * source codes, clock output selections, wake source bit positions.
 * Assumes inclusion by bare name from the rtl/ directory.
 */
`ifndef PWR_MODE_DEFINES_VH
`define PWR_MODE_DEFINES_VH

`define ST_NORMAL 2'h0
`define ST_WAIT 2'h1
`define ST_STOP 2'h2

`define CLK_MAIN 2'h0
`define CLK_SUB 2'h1
`define CLK_OCO 2'h2
`define CLK_PLL 2'h3

`define CKO_PORT 3'h0
`define CKO_SUB 3'h1
`define CKO_F8 3'h2
`define CKO_F32 3'h3
`define CKO_F1 3'h4

`define PRIO_OFF 3'h0

// Wake source indices
`define WK_KEY 0
`define WK_PIN 1
`define WK_SER 2
`define WK_ADC 3
`define WK_TMR 4
`define WK_VDD 5
`define WK_NUM 6

`endif

// *** rtl/wake_qualify.v ***
/*
 * Qualifies per-source peripheral interrupt requests as wake requests,
 * according to mode (wait or stop), clock-stop-in-wait and source setup.
 * Assumes all inputs already sit in the system clock domain.
 */
`timescale 1ns/1ps
`include "pwr_mode_defines.vh"
module wake_qualify #(
    parameter NSRC = `WK_NUM
) (
    input wire i_in_stop,
    input wire i_periph_clk_stop_in_wait,
    input wire i_global_int_enable,
    input wire [NSRC*3-1:0] i_interrupt_priority_level,
    input wire [NSRC-1:0] i_req,
    input wire i_ser_ext_clk,
    input wire i_adc_single_mode,
    input wire i_tmr_ext_or_sub32,
    output wire o_wake
);
    wire [NSRC-1:0] allowed;
    wire [NSRC-1:0] qual;
    wire restrict_clk;

    // Internal clocks are down in stop, or in wait with gating on
    assign restrict_clk = i_in_stop | i_periph_clk_stop_in_wait;

    assign allowed[`WK_KEY] = 1'b1;
    assign allowed[`WK_PIN] = 1'b1;
    assign allowed[`WK_SER] = ~restrict_clk | i_ser_ext_clk;
    assign allowed[`WK_ADC] = ~restrict_clk & i_adc_single_mode;
    assign allowed[`WK_TMR] = ~restrict_clk | i_tmr_ext_or_sub32;
    assign allowed[`WK_VDD] = i_in_stop | ~i_periph_clk_stop_in_wait;

    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_src
            assign qual[g] = i_req[g] & allowed[g] &
                (i_interrupt_priority_level[g*3 +: 3] != `PRIO_OFF);
        end
    endgenerate

    assign o_wake = i_global_int_enable & (|qual);
endmodule // wake_qualify

// *** test/clk_tree_model.sv ***
/* Clock tree model: free running sub, f1, f8 and f32 levels.
   Assumes the system clock feeds the dividers. */
`timescale 1ns/1ps
module clk_tree_model (
    input wire logic i_sys_clk,
    output logic o_sub_clk,
    output logic o_f1,
    output logic o_f8,
    output logic o_f32
);
    // ========
    // Oscillators never stop here
    logic [5:0] div_ff = 6'h00;
    always @(posedge i_sys_clk) begin
        div_ff <= div_ff + 6'h01;
    end
    assign o_f1 = div_ff[0];
    assign o_f8 = div_ff[2];
    assign o_f32 = div_ff[4];
    assign o_sub_clk = div_ff[5];
endmodule // clk_tree_model

// *** test/pwr_mode_chk_assertions.sv ***
/* Port checker for the wait/stop power mode controller.
   Assumes it is bound into pwr_mode_ctrl and sees its ports by name. */
`timescale 1ns/1ps
module pwr_mode_chk #(
    parameter NSRC = 6,
    parameter NPINS = 8
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_clk_en,
    input wire i_wait_instr,
    input wire i_all_clock_stop_wr,
    input wire [1:0] i_cpu_clk_src,
    input wire i_wdt_osc_source_select,
    input wire i_periph_clk_stop_in_wait,
    input wire [2:0] i_clk_out_select,
    input wire i_nmi_n,
    input wire o_in_wait,
    input wire o_in_stop,
    input wire o_cpu_clk_en,
    input wire o_wdt_clk_en,
    input wire o_periph_clk_en,
    input wire o_sub_div32_en,
    input wire o_main_osc_en,
    input wire o_sub_osc_en,
    input wire o_oco_en,
    input wire o_pll_osc_en,
    input wire [1:0] o_cpu_clk_src,
    input wire o_cpu_div8_select,
    input wire o_main_osc_high_drive,
    input wire o_wake_irq,
    input wire [NPINS-1:0] o_port_out,
    input wire [NPINS-1:0] o_port_dir,
    input wire o_clock_output_pin
);
    // ========
    // Source held at mode entry
    wire normal = !o_in_wait && !o_in_stop;
    logic [1:0] src_ff = 2'h0;
    always @(posedge i_sys_clk) begin
        if (normal && i_clk_en && (i_wait_instr || i_all_clock_stop_wr)) begin
            src_ff <= i_cpu_clk_src;
        end
    end
    // ========
    // Properties
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_go_wait;
        normal && i_clk_en && i_wait_instr && !i_all_clock_stop_wr;
    endsequence
    sequence s_go_stop;
        normal && i_clk_en && i_all_clock_stop_wr;
    endsequence
    property p_wait_enter;
        s_go_wait |=> o_in_wait && !o_in_stop && !o_cpu_clk_en;
    endproperty
    a_wait_enter: assert property (p_wait_enter) else $error("wait entry");
    property p_wdt;
        s_go_wait |=> o_wdt_clk_en == $past(i_wdt_osc_source_select);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog gate");
    property p_osc_wait;
        s_go_wait |=> o_main_osc_en && o_sub_osc_en && o_oco_en && o_pll_osc_en && o_sub_div32_en;
    endproperty
    a_osc_wait: assert property (p_osc_wait) else $error("osc in wait");
    property p_periph;
        s_go_wait |=> o_periph_clk_en == !$past(i_periph_clk_stop_in_wait);
    endproperty
    a_periph: assert property (p_periph) else $error("periph gate");
    property p_stop_enter;
        s_go_stop |=> o_in_stop && !o_in_wait && !o_main_osc_en && !o_sub_osc_en && !o_oco_en
            && !o_pll_osc_en && !o_cpu_clk_en && !o_periph_clk_en && o_cpu_div8_select && o_main_osc_high_drive;
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop entry");
    property p_pins;
        !normal && ($past(o_in_wait) || $past(o_in_stop)) |-> $stable(o_port_out) && $stable(o_port_dir);
    endproperty
    a_pins: assert property (p_pins) else $error("pins moved");
    property p_nmi_wake;
        !normal && $fell(i_nmi_n) |-> ##[1:5] normal;
    endproperty
    a_nmi_wake: assert property (p_nmi_wake) else $error("nmi wake");
    property p_wait_ret;
        $fell(o_in_wait) |-> o_cpu_clk_en && o_cpu_clk_src == src_ff;
    endproperty
    a_wait_ret: assert property (p_wait_ret) else $error("wait return");
    property p_stop_ret;
        $fell(o_in_stop) |-> o_cpu_clk_en && o_cpu_clk_src == src_ff && o_cpu_div8_select;
    endproperty
    a_stop_ret: assert property (p_stop_ret) else $error("stop return");
    property p_irq;
        o_wake_irq |-> normal && ($past(o_in_wait) || $past(o_in_stop));
    endproperty
    a_irq: assert property (p_irq) else $error("wake pulse");
    property p_cko_stop;
        o_in_stop && $past(o_in_stop) |-> $stable(o_clock_output_pin);
    endproperty
    a_cko_stop: assert property (p_cko_stop) else $error("clock out in stop");
    // Divided clocks on the output pin freeze in wait when gating is on; select 1 is the sub clock
    property p_cko_wait;
        o_in_wait && $past(o_in_wait) && $past(i_periph_clk_stop_in_wait) && ($past(i_clk_out_select) != 3'h1)
            |-> $stable(o_clock_output_pin);
    endproperty
    a_cko_wait: assert property (p_cko_wait) else $error("clock out in wait");
endmodule // pwr_mode_chk

bind pwr_mode_ctrl pwr_mode_chk #(.NSRC(NSRC), .NPINS(NPINS)) i_pwr_mode_chk (.*);

// *** test/tb.sv ***
/* Self-checking bench for the power mode controller.
   Assumes rtl/ is on the include path. */
`timescale 1ns/1ps
`include "pwr_mode_defines.vh"
module tb;
    logic clk = 0, rst = 1, wait_i = 0, stop_i = 0, div8 = 0, hdrv = 0, wdt = 0, periph_clk_stop_in_wait = 0;
    logic gie = 0, ser = 0, adc = 0, tmr = 0, nmi_n = 1, ce = 1;
    bit hung = 1'b0;
    logic [1:0] src = 2'h0, o_src;
    logic [17:0] prio = 18'h00000;
    logic [2:0] cko = 3'h0;
    logic [5:0] irq = 6'h00, e;
    logic [7:0] pout = 8'h00, pdir = 8'h00;
    logic sub, f1, f8, f32, o_wait, o_stop, o_cpu, o_wk;
    logic [1:0] last = 2'h0;
    logic [5:0] exp_q[$];
    int miscompares = 0, tests_run = 0;
    clk_tree_model i_clk_tree_model (.i_sys_clk(clk), .o_sub_clk(sub), .o_f1(f1), .o_f8(f8), .o_f32(f32));
    pwr_mode_ctrl i_pwr_mode_ctrl (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(ce), .i_wait_instr(wait_i),
        .i_all_clock_stop_wr(stop_i), .i_cpu_clk_src(src), .i_cpu_div8_select(div8),
        .i_main_osc_high_drive(hdrv), .i_wdt_osc_source_select(wdt), .i_periph_clk_stop_in_wait(periph_clk_stop_in_wait),
        .i_global_int_enable(gie), .i_interrupt_priority_level(prio), .i_clk_out_select(cko),
        .i_ser_ext_clk(ser), .i_adc_single_mode(adc), .i_tmr_ext_or_sub32(tmr), .i_nmi_n(nmi_n),
        .i_periph_irq(irq), .i_port_out(pout), .i_port_dir(pdir), .i_sub_clk(sub), .i_f1(f1), .i_f8(f8),
        .i_f32(f32), .o_in_wait(o_wait), .o_in_stop(o_stop), .o_cpu_clk_en(o_cpu), .o_wdt_clk_en(),
        .o_periph_clk_en(), .o_sub_div32_en(), .o_main_osc_en(), .o_sub_osc_en(), .o_oco_en(),
        .o_pll_osc_en(), .o_cpu_clk_src(o_src), .o_cpu_div8_select(), .o_main_osc_high_drive(),
        .o_wake_irq(o_wk), .o_port_out(), .o_port_dir(), .o_clock_output_pin());
    initial begin
        forever #2 clk = ~clk;
    end
    // ========
    // Checking
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
        end
    endtask
    task stop_test;
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Every mode change consumes the oldest expectation
    always @(negedge clk) begin
        if (!rst && {o_wait, o_stop} !== last) begin
            last = {o_wait, o_stop};
            if (exp_q.size() == 0) begin
                chk("mode", {o_wait, o_stop}, 8'hff);
            end else begin
                e = exp_q.pop_front();
                chk("mode", {o_wait, o_stop, o_cpu, o_wk}, e[5:2]);
                if (last === 2'h0) chk("cpu_src", o_src, e[1:0]);
            end
        end
        pout <= 8'($urandom);
        pdir <= 8'($urandom);
    end
    // ========
    // Stimulus
    function automatic bit allowed(input bit stp, input int k);
        bit lo;
        lo = !stp && !periph_clk_stop_in_wait;
        case (k)
            `WK_SER: allowed = ser || lo;
            `WK_ADC: allowed = lo && adc;
            `WK_TMR: allowed = tmr || lo;
            `WK_VDD: allowed = stp || !periph_clk_stop_in_wait;
            default: allowed = 1'b1;
        endcase
    endfunction
    task automatic run_one(input bit stp);
        int k, i;
        bit ok;
        k = $urandom_range(`WK_NUM - 1);
        src = 2'($urandom_range(2));
        {periph_clk_stop_in_wait, ser, adc, tmr, gie, wdt, div8, hdrv} = 8'($urandom);
        cko = 3'($urandom_range(4));
        prio = 18'h00000;
        prio[3*k +: 3] = 3'($urandom);
        ok = allowed(stp, k) && prio[3*k +: 3] !== 3'h0 && gie;
        @(negedge clk);
        stop_i = stp;
        wait_i = 1'b1;
        exp_q.push_back({!stp, stp, 4'h0});
        exp_q.push_back({3'h1, ok, src});
        @(negedge clk);
        {stop_i, wait_i} = 2'h0;
        @(negedge clk);
        wait_i = 1'b1;
        @(negedge clk);
        wait_i = 1'b0;
        irq[k] = 1'b1;
        ce = 1'b0;
        repeat (8) @(negedge clk);
        chk("frozen", {o_wait, o_stop}, {!stp, stp});
        ce = 1'b1;
        if (!ok) nmi_n = 1'b0;
        for (i = 0; i < 12 && {o_wait, o_stop} !== 2'h0; i++) @(negedge clk);
        if (i == 12) begin
            miscompares++;
            hung = 1'b1;
        end
        nmi_n = 1'b1;
        irq = 6'h00;
        repeat (4) @(negedge clk);
        chk("pending", 8'(exp_q.size()), 8'h00);
    endtask
    initial begin
        void'($urandom(32'h1ebb));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        for (int n = 0; n < 40 && !hung; n++) run_one(n[0]);
        stop_test;
    end
endmodule // tb
